// ===== hw/ssrc_map.vh
// register map, field layout and timing constants of the slot repeat sequencer
`ifndef SSRC_MAP_VH
`define SSRC_MAP_VH

// register indices; byte address is four times the index
`define SSRC_IDX_REPEAT_LOW 6'h17
`define SSRC_IDX_REPEAT_HIGH 6'h18
`define SSRC_IDX_STATUS 6'h20
`define SSRC_ADDR_W 8
`define SSRC_DATA_W 32
`define SSRC_REG_W 8
`define SSRC_REPEAT_RESET 8'h00
`define SSRC_IDX_W 6
`define SSRC_IDX_LSB 2
`define SSRC_BE_LOW 0

// field layout
`define SSRC_SLOTS 8
`define SSRC_CNT_W 2
`define SSRC_ID_W 7
`define SSRC_SLOT_W 4
`define SSRC_ID_STOP 7'h00
`define SSRC_SLOT_END 4'h8
`define SSRC_SLOTS_PER_REG 4
`define SSRC_SEL_W 3

// status register fields
`define SSRC_ST_BUSY 7
`define SSRC_ST_PASS_LSB 4
`define SSRC_ST_SLOT_LSB 0

// wait timing
`define SSRC_WAIT_UNIT_MS 10
`define SSRC_CLK_KHZ 200000
`define SSRC_TICK_W 22
`define SSRC_TICK_ONE 22'h000001
`define SSRC_UNIT_LAST 7'h01

`endif

// ===== hw/ssrc_sequencer.v
// slot repeat count registers and eight-slot sequence walker
//
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/100ps
`include "ssrc_map.vh"

module ssrc_sequencer #(
	parameter UNIT_CYCLES = `SSRC_WAIT_UNIT_MS * `SSRC_CLK_KHZ
) (
	input wire core_clk,
	input wire rstn,
	input wire [`SSRC_ADDR_W-1:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [`SSRC_DATA_W-1:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	output reg [`SSRC_DATA_W-1:0] avs_readdata,
	output reg avs_waitrequest,
	input wire seq_start,
	input wire [`SSRC_SLOTS-1:0] slot_delay_select,
	input wire [`SSRC_SLOTS*`SSRC_ID_W-1:0] slot_effect_identifier,
	output reg play_req,
	output reg [`SSRC_ID_W-1:0] play_id,
	input wire play_done,
	output reg seq_busy,
	output reg seq_done
);

localparam [2:0] ST_IDLE = 3'h0;
localparam [2:0] ST_FETCH = 3'h1;
localparam [2:0] ST_PLAY = 3'h2;
localparam [2:0] ST_WAIT = 3'h3;
localparam [2:0] ST_NEXT = 3'h4;
// a unit longer than the tick counter can hold is cut; widen the counter with it
localparam [31:0] TICK_LAST_FULL = UNIT_CYCLES - 1;
localparam [`SSRC_TICK_W-1:0] TICK_LAST = TICK_LAST_FULL[`SSRC_TICK_W-1:0];

// ----------------------------------------
// register file
// ----------------------------------------
reg [`SSRC_REG_W-1:0] slot_repeat_counts_low;
reg [`SSRC_REG_W-1:0] slot_repeat_counts_high;
reg [2:0] state;
reg [`SSRC_SLOT_W-1:0] slot_idx;
reg [`SSRC_CNT_W-1:0] pass_cnt;
reg [`SSRC_ID_W-1:0] wait_units;
reg [`SSRC_TICK_W-1:0] tick_cnt;

// byte and half-word offsets are answered with zero and never store
wire [`SSRC_IDX_W-1:0] reg_idx = avs_address[`SSRC_ADDR_W-1:`SSRC_IDX_LSB];
wire addr_word = (avs_address[`SSRC_IDX_LSB-1:0] == {`SSRC_IDX_LSB{1'b0}});
// the write lands on the answer edge, the only edge the master samples it
wire wr_take = avs_write && !avs_waitrequest && avs_byteenable[`SSRC_BE_LOW] && addr_word;

// ----------------------------------------
// slot field selection
// ----------------------------------------
// one two-bit field per slot; the first half of the slots sit in the low register
wire [`SSRC_CNT_W*`SSRC_SLOTS-1:0] all_counts;
genvar gi;
generate
	for (gi = 0; gi < `SSRC_SLOTS; gi = gi + 1) begin : g_slot_cnt
		if (gi < `SSRC_SLOTS_PER_REG) begin : g_low
			// slots one to four in low register
			// third slot, gi two, takes bits five and four
			assign all_counts[gi*`SSRC_CNT_W +: `SSRC_CNT_W] =
				slot_repeat_counts_low[gi*`SSRC_CNT_W +: `SSRC_CNT_W];
		end else begin : g_high
			// slots five to eight in high register
			assign all_counts[gi*`SSRC_CNT_W +: `SSRC_CNT_W] =
				slot_repeat_counts_high[(gi-`SSRC_SLOTS_PER_REG)*`SSRC_CNT_W +: `SSRC_CNT_W];
		end
	end
endgenerate

wire [`SSRC_SEL_W-1:0] slot_sel = slot_idx[`SSRC_SEL_W-1:0];
wire [`SSRC_CNT_W-1:0] cur_repeat = all_counts[slot_sel*`SSRC_CNT_W +: `SSRC_CNT_W];
wire [`SSRC_ID_W-1:0] cur_id = slot_effect_identifier[slot_sel*`SSRC_ID_W +: `SSRC_ID_W];
wire cur_delay = slot_delay_select[slot_sel];

// ----------------------------------------
// walker decode
// ----------------------------------------
// walk ends at the slot past the last one or at a zero identifier
wire seq_end = (slot_idx == `SSRC_SLOT_END) || (cur_id == `SSRC_ID_STOP);
// counts are read live, so a write during a walk acts from the next pass on
wire last_pass = (pass_cnt == cur_repeat);
wire last_tick = (tick_cnt == TICK_LAST);
wire last_unit = (wait_units == `SSRC_UNIT_LAST);

reg [`SSRC_DATA_W-1:0] next_readdata;
always @* begin
	next_readdata = {`SSRC_DATA_W{1'b0}};
	if (addr_word) begin
		case (reg_idx)
			`SSRC_IDX_REPEAT_LOW: next_readdata[`SSRC_REG_W-1:0] = slot_repeat_counts_low;
			`SSRC_IDX_REPEAT_HIGH: next_readdata[`SSRC_REG_W-1:0] = slot_repeat_counts_high;
			`SSRC_IDX_STATUS: begin
				next_readdata[`SSRC_ST_BUSY] = seq_busy;
				next_readdata[`SSRC_ST_PASS_LSB +: `SSRC_CNT_W] = pass_cnt;
				next_readdata[`SSRC_ST_SLOT_LSB +: `SSRC_SLOT_W] = slot_idx;
			end
			default: next_readdata = {`SSRC_DATA_W{1'b0}};
		endcase
	end
end

// ----------------------------------------
// avalon slave
// ----------------------------------------
// one wait state: the request is seen, then answered on the next edge
// readdata is loaded for writes too; a writing master ignores it
always @(posedge core_clk or negedge rstn) begin
	if (!rstn) begin
		avs_waitrequest <= 1'b1;
		avs_readdata <= {`SSRC_DATA_W{1'b0}};
		slot_repeat_counts_low <= `SSRC_REPEAT_RESET;
		slot_repeat_counts_high <= `SSRC_REPEAT_RESET;
	end else begin
		if (avs_waitrequest && (avs_read || avs_write)) begin
			avs_waitrequest <= 1'b0;
			avs_readdata <= next_readdata;
		end else begin
			avs_waitrequest <= 1'b1;
		end
		if (wr_take && reg_idx == `SSRC_IDX_REPEAT_LOW)
			slot_repeat_counts_low <= avs_writedata[`SSRC_REG_W-1:0];
		if (wr_take && reg_idx == `SSRC_IDX_REPEAT_HIGH)
			slot_repeat_counts_high <= avs_writedata[`SSRC_REG_W-1:0];
	end
end

// ----------------------------------------
// sequence walker
// ----------------------------------------
always @(posedge core_clk or negedge rstn) begin
	if (!rstn) begin
		state <= ST_IDLE;
		slot_idx <= {`SSRC_SLOT_W{1'b0}};
		pass_cnt <= {`SSRC_CNT_W{1'b0}};
		wait_units <= {`SSRC_ID_W{1'b0}};
		tick_cnt <= {`SSRC_TICK_W{1'b0}};
		play_req <= 1'b0;
		play_id <= {`SSRC_ID_W{1'b0}};
		seq_busy <= 1'b0;
		seq_done <= 1'b0;
	end else begin
		seq_done <= 1'b0;
		case (state)
			ST_IDLE: begin
				// start is only looked at here, so a walk in progress is never restarted
				if (seq_start) begin
					slot_idx <= {`SSRC_SLOT_W{1'b0}};
					pass_cnt <= {`SSRC_CNT_W{1'b0}};
					seq_busy <= 1'b1;
					state <= ST_FETCH;
				end
			end
			ST_FETCH: begin
				if (seq_end) begin
					seq_busy <= 1'b0;
					seq_done <= 1'b1;
					state <= ST_IDLE;
				end else if (cur_delay) begin
					wait_units <= cur_id;
					tick_cnt <= {`SSRC_TICK_W{1'b0}};
					state <= ST_WAIT;
				end else begin
					play_req <= 1'b1;
					play_id <= cur_id;
					state <= ST_PLAY;
				end
			end
			ST_PLAY: begin
				// no timeout: a player that never reports done holds the walk here
				if (play_done) begin
					play_req <= 1'b0;
					state <= ST_NEXT;
				end
			end
			ST_WAIT: begin
				// ten millisecond units
				// a zero identifier never gets here: it ends the walk in fetch
				if (last_tick) begin
					tick_cnt <= {`SSRC_TICK_W{1'b0}};
					wait_units <= wait_units - 1'b1;
					if (last_unit)
						state <= ST_NEXT;
				end else begin
					tick_cnt <= tick_cnt + `SSRC_TICK_ONE;
				end
			end
			ST_NEXT: begin
				if (last_pass) begin
					pass_cnt <= {`SSRC_CNT_W{1'b0}};
					slot_idx <= slot_idx + 1'b1;
				end else begin
					pass_cnt <= pass_cnt + 1'b1;
				end
				state <= ST_FETCH;
			end
			default: state <= ST_IDLE;
		endcase
	end
end

endmodule // ssrc_sequencer

// ===== sim/ssrc_seq_sva.sv
// port checker for the slot repeat sequencer
`timescale 1ns/100ps
module ssrc_seq_chk (input logic core_clk, input logic rstn, input logic avs_read,
	input logic avs_write, input logic [31:0] avs_readdata, input logic avs_waitrequest,
	input logic seq_start, input logic [7:0] slot_delay_select,
	input logic [55:0] slot_effect_identifier, input logic play_req,
	input logic [6:0] play_id, input logic play_done, input logic seq_busy,
	input logic seq_done);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	AST_ANS: assert property ((avs_read || avs_write) && avs_waitrequest |=>
		!avs_waitrequest)
		else $error("bus answer late");
	AST_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("answer too long");
	AST_RDZ: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
		else $error("upper read bits set");
	AST_GO: assert property (seq_start && !seq_busy |=> seq_busy)
		else $error("start not taken");
	AST_FIRST: assert property (seq_start && !seq_busy && !slot_delay_select[0] &&
		slot_effect_identifier[6:0] != 7'h00 |=> ##1
		play_req && play_id == slot_effect_identifier[6:0])
		else $error("first play wrong");
	AST_HOLD: assert property (play_req && !play_done |=> play_req && $stable(play_id))
		else $error("play dropped early");
	AST_DROP: assert property (play_req && play_done |=> !play_req ##1 !play_req)
		else $error("play not ended");
	AST_NZ: assert property (play_req |-> play_id != 7'h00 && seq_busy)
		else $error("zero id played");
	AST_END: assert property (seq_done |-> !seq_busy && $past(seq_busy))
		else $error("done without busy end");
	AST_DLY: assert property (seq_start && !seq_busy && slot_delay_select[0] |=>
		!play_req [*5])
		else $error("delay slot played");
	cover property (play_req && play_done);
	cover property (seq_done);
	cover property (avs_write && !avs_waitrequest);
	cover property (seq_start && !seq_busy && slot_delay_select[0]);
endmodule // ssrc_seq_chk
bind ssrc_sequencer ssrc_seq_chk u_chk (.core_clk(core_clk), .rstn(rstn), .avs_read(avs_read),
	.avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.seq_start(seq_start), .slot_delay_select(slot_delay_select),
	.slot_effect_identifier(slot_effect_identifier), .play_req(play_req), .play_id(play_id),
	.play_done(play_done), .seq_busy(seq_busy), .seq_done(seq_done));

// ===== sim/tb.sv
// self-checking bench for the slot repeat sequencer
`timescale 1ns/100ps
module tb;
	localparam int U = 4;
	logic core_clk = 0, rstn = 0, rd = 0, wr = 0, start = 0, pdone = 0, preq, wreq, busy, done;
	logic [7:0] addr = 8'h00, dsel = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, q;
	logic [3:0] be = 4'hF;
	logic [55:0] ids = 56'h0;
	logic [6:0] pid;
	integer failures = 0, n_checks = 0, plays [0:127], d [0:3], j, k;
	ssrc_sequencer #(.UNIT_CYCLES(U)) u_dut (.core_clk(core_clk), .rstn(rstn),
		.avs_address(addr), .avs_read(rd), .avs_write(wr), .avs_writedata(wdata),
		.avs_byteenable(be), .avs_readdata(rdata), .avs_waitrequest(wreq), .seq_start(start),
		.slot_delay_select(dsel), .slot_effect_identifier(ids), .play_req(preq),
		.play_id(pid), .play_done(pdone), .seq_busy(busy), .seq_done(done));
	initial forever #2.5 core_clk = ~core_clk;
	// player answers each request one cycle late so every play is counted once
	always @(posedge core_clk) begin
		pdone <= preq && !pdone;
		if (preq && !pdone)
			plays[pid] = plays[pid] + 1;
	end
	task results;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task chk(input [31:0] got, input [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask
	task bus(input bit w, input [7:0] a, input [31:0] dt, input [3:0] b);
		integer i;
		@(posedge core_clk);
		addr <= a;
		wr <= w;
		rd <= !w;
		wdata <= dt;
		be <= b;
		for (i = 0; i < 50; i++) begin
			@(posedge core_clk);
			if (wreq === 1'b0)
				break;
		end
		if (i == 50) begin
			failures++;
			results;
		end
		q = rdata;
		rd <= 0;
		wr <= 0;
	endtask
	task run(output integer n);
		for (k = 0; k < 128; k++)
			plays[k] = 0;
		@(posedge core_clk);
		start <= 1;
		@(posedge core_clk);
		start <= 0;
		// a second start while the walk is busy must be ignored
		@(posedge core_clk);
		start <= 1;
		@(posedge core_clk);
		start <= 0;
		for (n = 0; done !== 1'b1; n++) begin
			@(posedge core_clk);
			if (n > 3000) begin
				failures++;
				results;
			end
		end
		chk(busy, 0);
	endtask
	task regs_scn;
		bus(0, 8'h5C, 0, 4'hF);
		chk(q, 32'h0);
		bus(0, 8'h60, 0, 4'hF);
		chk(q, 32'h0);
		bus(0, 8'h80, 0, 4'hF);
		chk(q, 32'h0);
		bus(1, 8'h5C, 32'hFFFF_FFA5, 4'hF);
		bus(0, 8'h5C, 0, 4'hF);
		chk(q, 32'hA5);
		bus(1, 8'h60, 32'h5A, 4'hF);
		bus(1, 8'h60, 32'hFF, 4'h0);
		bus(0, 8'h60, 0, 4'hF);
		chk(q, 32'h5A);
		bus(1, 8'h04, 32'hFF, 4'hF);
		bus(0, 8'h04, 0, 4'hF);
		chk(q, 32'h0);
	endtask
	// distinct count per slot within each register exposes a swapped or shifted field inside a register
	task repeat_scn;
		bus(1, 8'h5C, 32'h39, 4'hF);
		bus(1, 8'h60, 32'h93, 4'hF);
		for (k = 1; k < 9; k++)
			ids[7*(k-1) +: 7] <= k;
		run(j);
		for (k = 1; k < 9; k++)
			chk(plays[k], 1 + ((k < 5 ? 32'h39 >> (2*k-2) : 32'h93 >> (2*k-10)) & 3));
		bus(0, 8'h80, 0, 4'hF);
		chk(q, 32'h08);
	endtask
	task delay_scn;
		dsel <= 8'h01;
		for (j = 0; j < 4; j++) begin
			ids <= j[0] ? 56'h3 : 56'h1;
			bus(1, 8'h5C, j[1], 4'hF);
			run(d[j]);
			chk(plays[1] + plays[3], 0);
		end
		chk(d[1] - d[0], 2 * U);
		chk(d[3] - d[2], 4 * U);
		bus(0, 8'h80, 0, 4'hF);
		chk(q, 32'h01);
	endtask
	// a reset while idle after the walks must return both count registers to zero
	task reset_scn;
		@(posedge core_clk);
		rstn <= 0;
		repeat (3) @(posedge core_clk);
		rstn <= 1;
		bus(0, 8'h5C, 0, 4'hF);
		chk(q, 32'h0);
		bus(0, 8'h60, 0, 4'hF);
		chk(q, 32'h0);
	endtask
	initial begin
		repeat (12) @(posedge core_clk);
		rstn <= 1;
		regs_scn;
		repeat_scn;
		delay_scn;
		reset_scn;
		results;
	end
endmodule // tb
